//--- src/stp_pkg.sv
// constants, register map and state type of the synth tuning and power table block
package stp_pkg;
	// register addresses on the internal register port
	localparam logic [7:0] ADDR_BASE_HIGH = 8'h00;
	localparam logic [7:0] ADDR_BASE_MID = 8'h01;
	localparam logic [7:0] ADDR_BASE_LOW = 8'h02;
	localparam logic [7:0] ADDR_SLOT = 8'h03;
	localparam logic [7:0] ADDR_MODEM_LOW = 8'h04;
	localparam logic [7:0] ADDR_MODEM_HIGH = 8'h05;
	localparam logic [7:0] ADDR_SYNTH_CTRL = 8'h06;
	localparam logic [7:0] ADDR_RADIO_CFG = 8'h07;
	localparam logic [7:0] ADDR_PIN_CFG = 8'h08;
	localparam logic [7:0] ADDR_FRONT_END = 8'h09;
	localparam logic [7:0] ADDR_CAL_RESULT = 8'h0A;
	localparam logic [7:0] ADDR_POWER_TABLE = 8'h0B;
	// reset values
	localparam logic [7:0] RST_BASE_HIGH = 8'h00;
	localparam logic [7:0] RST_BASE_MID = 8'h00;
	localparam logic [7:0] RST_BASE_LOW = 8'h00;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_POWER_ENTRY0 = 8'hC6;
	localparam logic [5:0] RST_CAL_RESULT = 6'h3F;
	// field positions and codes
	localparam int EXP_LSB = 0;
	localparam int AUTOCAL_LSB = 4;
	localparam int PWR_IDX_LSB = 0;
	localparam logic [5:0] SEL_LOCK = 6'h0A;
	localparam logic [5:0] CAL_NO_LOCK = 6'h3F;
	localparam logic [1:0] AUTOCAL_ON_START = 2'h1;
	localparam logic [1:0] AUTOCAL_ON_STOP = 2'h2;
	localparam logic [8:0] SPACING_OFFSET = 9'h100;
	// times
	localparam int CLK_PERIOD_NS = 5;
	localparam int RAMP_STEP_NS = 100;
	localparam int RAMP_STEP_CYCLES = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CAL_TIME_NS = 712000;
	localparam int CAL_CYCLES_DEF = CAL_TIME_NS / CLK_PERIOD_NS;
	typedef enum logic [2:0] {ST_IDLE, ST_CAL, ST_ACTIVE, ST_RAMP_DOWN, ST_SLEEP} stp_state_t;
endpackage : stp_pkg

//--- src/stp_synth_power.sv
// synthesizer tuning, calibration control and output power table
// What this block does
// - base word is 24 bits over three bytes
// - 8-bit slot number scales spacing onto base
// - word = base + slot*(256+m)*2^(e-2)
// - spacing held as mantissa and exponent fields
// - IF word is crystal/2^10 times offset word
// - auto calibration on start or auto stop
// - calibrate strobe in idle starts calibration
// - calibration result survives sleep
// - selector 0x0A drives lock onto output pin
// - calibration result is vco_cal_code when locked, 0x3F otherwise
// - eight power entries chosen by 3-bit index
// - frequency-shift ramps entries 0..index, zero disables
// - on-off keying sends entry 0 or 1
// - power entry 0 resets to 0xC6
// - entries above 0 written only in burst
// - sleep discards all entries except entry 0
`timescale 1ns/1ps
`default_nettype none
module stp_synth_power
	import stp_pkg::*;
#(
	parameter int CAL_CYCLES = CAL_CYCLES_DEF,
	parameter int TABLE_DEPTH = 8
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic reg_burst,
	output logic [7:0] reg_rdata,
	input wire logic cal_strobe,
	input wire logic start_req,
	input wire logic start_tx,
	input wire logic stop_req,
	input wire logic stop_auto,
	input wire logic sleep_req,
	input wire logic wake_req,
	input wire logic ook_mode,
	input wire logic ook_symbol,
	input wire logic pll_lock_in,
	input wire logic [5:0] vco_cal_code,
	output logic [24:0] synth_word,
	output logic [7:0] if_word,
	output logic synth_run,
	output logic cal_busy,
	output logic radio_idle,
	output logic [7:0] pa_level,
	output logic pa_enable,
	output logic general_output_pin
);
	logic [7:0] base_word_high_reg;
	logic [7:0] base_word_mid_reg;
	logic [7:0] base_word_low_reg;
	logic [7:0] slot_number_reg;
	logic [7:0] modem_config_low_reg;
	logic [7:0] modem_config_high_reg;
	logic [7:0] synth_control_one_reg;
	logic [7:0] radio_state_config_reg;
	logic [7:0] output_pin_config_reg;
	logic [7:0] front_end_tx_config_reg;
	logic [5:0] synth_cal_result_reg;
	logic [7:0] power_table_reg [TABLE_DEPTH];
	logic [2:0] table_ptr_reg;
	logic [7:0] rdata_reg;
	stp_state_t state_reg;
	stp_state_t state_next;
	logic [17:0] cal_cnt_reg;
	logic cal_then_run_reg;
	logic tx_reg;
	logic [2:0] ramp_idx_reg;
	logic [7:0] ramp_cnt_reg;
	logic [24:0] synth_word_reg;
	logic [7:0] if_word_reg;
	logic [7:0] pa_level_reg;
	logic pa_enable_reg;
	logic gen_out_reg;
	logic lock_q1_reg;
	logic lock_q2_reg;
	logic lock_q3_reg;
	logic lock_reg;

	// decode
	wire logic wr_base_high = reg_wr && reg_addr == ADDR_BASE_HIGH;
	wire logic wr_base_mid = reg_wr && reg_addr == ADDR_BASE_MID;
	wire logic wr_base_low = reg_wr && reg_addr == ADDR_BASE_LOW;
	wire logic wr_slot = reg_wr && reg_addr == ADDR_SLOT;
	wire logic wr_modem_low = reg_wr && reg_addr == ADDR_MODEM_LOW;
	wire logic wr_modem_high = reg_wr && reg_addr == ADDR_MODEM_HIGH;
	wire logic wr_synth_ctrl = reg_wr && reg_addr == ADDR_SYNTH_CTRL;
	wire logic wr_radio_cfg = reg_wr && reg_addr == ADDR_RADIO_CFG;
	wire logic wr_pin_cfg = reg_wr && reg_addr == ADDR_PIN_CFG;
	wire logic wr_front_end = reg_wr && reg_addr == ADDR_FRONT_END;
	wire logic pt_access = (reg_wr || reg_rd) && reg_addr == ADDR_POWER_TABLE;
	// a single access always lands on entry 0; only a burst walks the pointer
	wire logic [2:0] pt_index = reg_burst ? table_ptr_reg : 3'h0;
	wire logic pt_write = reg_wr && reg_addr == ADDR_POWER_TABLE;

	// tuning arithmetic
	wire logic [23:0] base_word = {base_word_high_reg, base_word_mid_reg, base_word_low_reg};
	wire logic [1:0] spacing_exponent = modem_config_high_reg[EXP_LSB +: 2];
	wire logic [8:0] spacing_full = SPACING_OFFSET + {1'b0, modem_config_low_reg};
	wire logic [16:0] slot_product = 17'(slot_number_reg) * 17'(spacing_full);
	wire logic [19:0] slot_shifted = {3'h0, slot_product} << spacing_exponent;
	// the minus-two exponent bias drops two fraction bits of the offset
	wire logic [24:0] synth_next = {1'b0, base_word} + {7'h00, slot_shifted[19:2]};
	wire logic [1:0] auto_cal_mode = radio_state_config_reg[AUTOCAL_LSB +: 2];
	wire logic [2:0] power_index = front_end_tx_config_reg[PWR_IDX_LSB +: 3];
	wire logic [5:0] pin_selector = output_pin_config_reg[5:0];
	wire logic cal_done = state_reg == ST_CAL && cal_cnt_reg == 18'(CAL_CYCLES - 1);
	wire logic ramp_tick = ramp_cnt_reg == 8'(RAMP_STEP_CYCLES - 1);
	wire logic ramp_top = ramp_idx_reg == power_index;
	wire logic ramp_bottom = ramp_idx_reg == 3'h0;
	wire logic [2:0] ook_index = {2'h0, ook_symbol};
	wire logic [2:0] pa_index = ook_mode ? ook_index : ramp_idx_reg;
	wire logic pa_on_next = tx_reg && (state_reg == ST_ACTIVE || state_reg == ST_RAMP_DOWN);
	wire logic start_from_idle = state_reg == ST_IDLE && start_req;

	logic [7:0] rd_mux;
	always_comb begin
		unique case (reg_addr)
			ADDR_BASE_HIGH: rd_mux = base_word_high_reg;
			ADDR_BASE_MID: rd_mux = base_word_mid_reg;
			ADDR_BASE_LOW: rd_mux = base_word_low_reg;
			ADDR_SLOT: rd_mux = slot_number_reg;
			ADDR_MODEM_LOW: rd_mux = modem_config_low_reg;
			ADDR_MODEM_HIGH: rd_mux = modem_config_high_reg;
			ADDR_SYNTH_CTRL: rd_mux = synth_control_one_reg;
			ADDR_RADIO_CFG: rd_mux = radio_state_config_reg;
			ADDR_PIN_CFG: rd_mux = output_pin_config_reg;
			ADDR_FRONT_END: rd_mux = front_end_tx_config_reg;
			ADDR_CAL_RESULT: rd_mux = {2'h0, synth_cal_result_reg};
			ADDR_POWER_TABLE: rd_mux = power_table_reg[pt_index];
			default: rd_mux = RST_ZERO;
		endcase
	end

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (sleep_req)
					state_next = ST_SLEEP;
				else if (cal_strobe || (start_req && auto_cal_mode == AUTOCAL_ON_START))
					state_next = ST_CAL;
				else if (start_req)
					state_next = ST_ACTIVE;
			end
			ST_CAL: begin
				if (cal_done)
					state_next = cal_then_run_reg ? ST_ACTIVE : ST_IDLE;
			end
			ST_ACTIVE: begin
				if (stop_req)
					state_next = ST_RAMP_DOWN;
			end
			ST_RAMP_DOWN: begin
				if (ramp_bottom || ook_mode || !tx_reg)
					state_next = cal_then_run_reg ? ST_CAL : ST_IDLE;
			end
			ST_SLEEP: begin
				if (wake_req)
					state_next = ST_IDLE;
			end
		endcase
	end

	// configuration registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			base_word_high_reg <= RST_BASE_HIGH;
			base_word_mid_reg <= RST_BASE_MID;
			base_word_low_reg <= RST_BASE_LOW;
			slot_number_reg <= RST_ZERO;
			modem_config_low_reg <= RST_ZERO;
			modem_config_high_reg <= RST_ZERO;
			synth_control_one_reg <= RST_ZERO;
			radio_state_config_reg <= RST_ZERO;
			output_pin_config_reg <= RST_ZERO;
			front_end_tx_config_reg <= RST_ZERO;
		end else begin
			if (wr_base_high) base_word_high_reg <= reg_wdata;
			if (wr_base_mid) base_word_mid_reg <= reg_wdata;
			if (wr_base_low) base_word_low_reg <= reg_wdata;
			if (wr_slot) slot_number_reg <= reg_wdata;
			if (wr_modem_low) modem_config_low_reg <= reg_wdata;
			if (wr_modem_high) modem_config_high_reg <= reg_wdata;
			if (wr_synth_ctrl) synth_control_one_reg <= reg_wdata;
			if (wr_radio_cfg) radio_state_config_reg <= reg_wdata;
			if (wr_pin_cfg) output_pin_config_reg <= reg_wdata;
			if (wr_front_end) front_end_tx_config_reg <= reg_wdata;
		end
	end

	// power table: entry 0 keeps its value in sleep, the rest are lost
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < TABLE_DEPTH; i++)
				power_table_reg[i] <= (i == 0) ? RST_POWER_ENTRY0 : RST_ZERO;
		end else begin
			for (int i = 1; i < TABLE_DEPTH; i++)
				if (state_next == ST_SLEEP && state_reg != ST_SLEEP)
					power_table_reg[i] <= RST_ZERO;
			if (pt_write)
				power_table_reg[pt_index] <= reg_wdata;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			table_ptr_reg <= 3'h0;
			rdata_reg <= RST_ZERO;
		end else begin
			if (!reg_burst)
				table_ptr_reg <= 3'h0;
			else if (pt_access)
				table_ptr_reg <= table_ptr_reg + 3'h1;
			if (reg_rd)
				rdata_reg <= rd_mux;
		end
	end

	// lock pin input: three stages, a change counts when stages two and three agree
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lock_q1_reg <= 1'b0;
			lock_q2_reg <= 1'b0;
			lock_q3_reg <= 1'b0;
			lock_reg <= 1'b0;
		end else begin
			lock_q1_reg <= pll_lock_in;
			lock_q2_reg <= lock_q1_reg;
			lock_q3_reg <= lock_q2_reg;
			if (lock_q2_reg == lock_q3_reg)
				lock_reg <= lock_q3_reg;
		end
	end

	// state, calibration and ramp
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= ST_IDLE;
			cal_cnt_reg <= 18'h0_0000;
			cal_then_run_reg <= 1'b0;
			tx_reg <= 1'b0;
			ramp_idx_reg <= 3'h0;
			ramp_cnt_reg <= RST_ZERO;
			synth_cal_result_reg <= RST_CAL_RESULT;
		end else begin
			state_reg <= state_next;
			cal_cnt_reg <= (state_reg == ST_CAL && !cal_done) ? cal_cnt_reg + 18'h0_0001 : 18'h0_0000;
			if (start_from_idle) begin
				cal_then_run_reg <= auto_cal_mode == AUTOCAL_ON_START;
				tx_reg <= start_tx;
			end else if (state_reg == ST_IDLE && cal_strobe) begin
				cal_then_run_reg <= 1'b0;
			end else if (state_reg == ST_ACTIVE && stop_req) begin
				cal_then_run_reg <= stop_auto && auto_cal_mode == AUTOCAL_ON_STOP;
			end else if (cal_done || (state_reg == ST_RAMP_DOWN && state_next == ST_CAL)) begin
				cal_then_run_reg <= 1'b0;
			end
			// result held through sleep; only a finished calibration changes it
			if (cal_done)
				synth_cal_result_reg <= lock_reg ? vco_cal_code : CAL_NO_LOCK;
			ramp_cnt_reg <= (ramp_tick || state_reg != state_next) ? RST_ZERO : ramp_cnt_reg + 8'h01;
			if (state_reg == ST_ACTIVE && tx_reg && ramp_tick && !ramp_top)
				ramp_idx_reg <= ramp_idx_reg + 3'h1;
			else if (state_reg == ST_RAMP_DOWN && ramp_tick && !ramp_bottom)
				ramp_idx_reg <= ramp_idx_reg - 3'h1;
			else if (state_reg == ST_IDLE)
				ramp_idx_reg <= 3'h0;
		end
	end

	// outputs
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			synth_word_reg <= 25'h000_0000;
			if_word_reg <= RST_ZERO;
			pa_level_reg <= RST_ZERO;
			pa_enable_reg <= 1'b0;
			gen_out_reg <= 1'b0;
			synth_run <= 1'b0;
			cal_busy <= 1'b0;
			radio_idle <= 1'b1;
		end else begin
			// tuning is latched only when leaving idle, so edits never disturb a running synth
			if (start_from_idle || (state_reg == ST_IDLE && cal_strobe)) begin
				synth_word_reg <= synth_next;
				if_word_reg <= synth_control_one_reg;
			end
			pa_level_reg <= pa_on_next ? power_table_reg[pa_index] : RST_ZERO;
			pa_enable_reg <= pa_on_next;
			gen_out_reg <= pin_selector == SEL_LOCK && lock_reg;
			synth_run <= state_next == ST_ACTIVE || state_next == ST_RAMP_DOWN || state_next == ST_CAL;
			cal_busy <= state_next == ST_CAL;
			radio_idle <= state_next == ST_IDLE;
		end
	end
	assign reg_rdata = rdata_reg;
	assign synth_word = synth_word_reg;
	assign if_word = if_word_reg;
	assign pa_level = pa_level_reg;
	assign pa_enable = pa_enable_reg;
	assign general_output_pin = gen_out_reg;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_base_readback;
		wr_base_high ##2 (reg_rd && reg_addr == ADDR_BASE_HIGH && !reg_wr)
			|=> rdata_reg == $past(reg_wdata, 3);
	endproperty
	a_base_readback: assert property (p_base_readback) else $error("base high byte lost");
	property p_word_latch;
		start_from_idle |=> synth_word_reg == $past(synth_next);
	endproperty
	a_word_latch: assert property (p_word_latch) else $error("synth word not taken on start");
	property p_word_frozen;
		(state_reg == ST_ACTIVE) && $past(state_reg == ST_ACTIVE) |-> $stable(synth_word_reg);
	endproperty
	a_word_frozen: assert property (p_word_frozen) else $error("synth word changed while active");
	property p_manual_cal;
		(state_reg == ST_IDLE && cal_strobe && !sleep_req) |=> state_reg == ST_CAL;
	endproperty
	a_manual_cal: assert property (p_manual_cal) else $error("strobe did not start calibration");
	property p_auto_cal;
		(start_from_idle && !sleep_req && !cal_strobe && auto_cal_mode == AUTOCAL_ON_START) |=> cal_busy;
	endproperty
	a_auto_cal: assert property (p_auto_cal) else $error("start did not calibrate");
	property p_cal_result;
		cal_done && lock_reg |=> synth_cal_result_reg != CAL_NO_LOCK || $past(vco_cal_code) == CAL_NO_LOCK;
	endproperty
	a_cal_result: assert property (p_cal_result) else $error("locked but result reads unlocked");
	property p_sleep_keeps_cal;
		state_reg == ST_SLEEP |=> $stable(synth_cal_result_reg);
	endproperty
	a_sleep_keeps_cal: assert property (p_sleep_keeps_cal) else $error("result changed in sleep");
	property p_lock_pin;
		##1 pin_selector == SEL_LOCK && $past(pin_selector == SEL_LOCK) |-> general_output_pin == $past(lock_reg);
	endproperty
	a_lock_pin: assert property (p_lock_pin) else $error("lock not shown on pin");
	property p_single_write_entry0;
		pt_write && !reg_burst |=> power_table_reg[0] == $past(reg_wdata);
	endproperty
	a_single_write_entry0: assert property (p_single_write_entry0) else $error("single write missed entry 0");
	property p_sleep_clears;
		state_reg != ST_SLEEP ##1 state_reg == ST_SLEEP |-> power_table_reg[1] == RST_ZERO;
	endproperty
	a_sleep_clears: assert property (p_sleep_clears) else $error("table kept entry 1 in sleep");
	property p_ramp_bound;
		pa_enable && !ook_mode |-> ramp_idx_reg <= power_index || state_reg == ST_RAMP_DOWN;
	endproperty
	a_ramp_bound: assert property (p_ramp_bound) else $error("ramp passed the index");
	property p_ook_level;
		pa_on_next && ook_mode |=> pa_level == $past(power_table_reg[ook_index]);
	endproperty
	a_ook_level: assert property (p_ook_level) else $error("keying level wrong");
	c_cal_run: cover property (cal_busy ##1 state_reg == ST_ACTIVE);
	c_ramp_top: cover property (pa_enable && ramp_top && power_index == 3'h7);
	c_burst_write: cover property (pt_write && reg_burst && table_ptr_reg == 3'h7);
	c_sleep_wake: cover property (state_reg == ST_SLEEP ##1 state_reg == ST_IDLE);
endmodule : stp_synth_power
`default_nettype wire

//--- tb/stp_host_model.sv
// host model driving the register port of the synth tuning block
`timescale 1ns/1ps
`default_nettype none
module stp_host_model (
	input wire logic clk,
	input wire logic [7:0] reg_rdata,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	output logic reg_burst
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_burst = 1'b0;
	end

	// call at a falling edge; the next rising edge takes the access
	task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w,
		output logic [7:0] q);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = w;
		reg_rd = !w;
		@(negedge clk);
		q = reg_rdata;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		// an idle bus never shows the old byte, so stale data cannot pass
		reg_wdata = ~d;
		@(negedge clk);
	endtask : acc

	// table entries above 0 are only reachable this way
	task automatic burst(input logic [7:0] a, input logic w, inout logic [7:0] v [8]);
		reg_burst = 1'b1;
		reg_addr = a;
		for (int i = 0; i < 8; i++) begin
			reg_wdata = v[i];
			reg_wr = w;
			reg_rd = !w;
			@(negedge clk);
			if (!w) begin
				v[i] = reg_rdata;
			end
		end
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_burst = 1'b0;
		reg_wdata = ~reg_wdata;
		@(negedge clk);
	endtask : burst
endmodule : stp_host_model
`default_nettype wire

//--- tb/stp_synth_power_bench.sv
// self-checking bench for the synth tuning and power table block
`timescale 1ns/1ps
`default_nettype none
module stp_synth_power_bench;
	import stp_pkg::*;
	logic clk, arst_n, reg_wr, reg_rd, reg_burst, cal_strobe, start_req, start_tx;
	logic stop_req, stop_auto, sleep_req, wake_req, ook_mode, ook_symbol, pll_lock_in;
	logic synth_run, cal_busy, radio_idle, pa_enable, general_output_pin;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, if_word, pa_level, q;
	logic [5:0] vco_cal_code;
	logic [24:0] synth_word;
	logic [7:0] tbl [8];
	logic [31:0] seed = 32'h0000_8fb5;
	int miscompares, check_count, base, slot, mant, expo, ifw, off, cal, pt[8];
	int exp_q[$];

	stp_synth_power #(.CAL_CYCLES(10)) u_dut (.clk(clk), .arst_n(arst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_burst(reg_burst), .reg_rdata(reg_rdata), .cal_strobe(cal_strobe),
		.start_req(start_req), .start_tx(start_tx), .stop_req(stop_req),
		.stop_auto(stop_auto), .sleep_req(sleep_req), .wake_req(wake_req),
		.ook_mode(ook_mode), .ook_symbol(ook_symbol), .pll_lock_in(pll_lock_in),
		.vco_cal_code(vco_cal_code), .synth_word(synth_word), .if_word(if_word),
		.synth_run(synth_run), .cal_busy(cal_busy), .radio_idle(radio_idle),
		.pa_level(pa_level), .pa_enable(pa_enable),
		.general_output_pin(general_output_pin));
	stp_host_model u_host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_burst(reg_burst));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic results();
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results

	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e, input string m);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask : chk_byte

	task automatic chk_word(input logic [24:0] g, input logic [24:0] e, input string m);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask : chk_word

	task automatic chk_bit(input logic g, input logic e, input string m);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t: %s got %b", $time, m, g);
		end
	endtask : chk_bit

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_host.acc(a, d, 1'b1, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string m);
		u_host.acc(a, 8'h00, 1'b0, q);
		chk_byte(q, e, m);
	endtask : rd

	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask : pulse

	task automatic wait_for(ref logic s, input logic v, input int lim);
		for (int n = 0; n < lim && s !== v; n++) begin
			@(negedge clk);
		end
		if (s !== v) begin
			miscompares++;
			$display("wrong value at %0t: wait ran out", $time);
			results();
		end
	endtask : wait_for

	// ramp and hold levels are sampled mid-step so a step edge never races the check
	task automatic tx_run(input int idx);
		wr(ADDR_FRONT_END, 8'(idx));
		start_tx = 1'b1;
		pulse(start_req);
		repeat (11) @(negedge clk);
		for (int k = 0; k <= idx; k++) exp_q.push_back(pt[k]);
		exp_q.push_back(pt[idx]);
		while (exp_q.size() > 0) begin
			chk_byte(pa_level, 8'(exp_q.pop_front()), "ramp level");
			repeat (20) @(negedge clk);
		end
		chk_bit(pa_enable, 1'b1, "power on");
		pulse(stop_req);
		// entry 0 stands for a single cycle on the way down, so only entries above it are sampled
		repeat (10) @(negedge clk);
		for (int k = idx; k > 0; k--) exp_q.push_back(pt[k]);
		while (exp_q.size() > 0) begin
			chk_byte(pa_level, 8'(exp_q.pop_front()), "ramp down level");
			repeat (20) @(negedge clk);
		end
		wait_for(radio_idle, 1'b1, 400);
		@(negedge clk);
		chk_byte(pa_level, 8'h00, "power off");
		chk_bit(pa_enable, 1'b0, "power off");
	endtask : tx_run

	initial begin
		repeat (100000) @(posedge clk);
		miscompares++;
		$display("wrong value at %0t: run too long", $time);
		results();
	end

	initial begin
		{cal_strobe, start_req, start_tx, stop_req, stop_auto, sleep_req} = '0;
		{wake_req, ook_mode, ook_symbol, pll_lock_in} = '0;
		vco_cal_code = 6'h00;
		arst_n = 1'b0;
		repeat (4) @(negedge clk);
		arst_n = 1'b1;
		@(negedge clk);
		rd(ADDR_POWER_TABLE, 8'hc6, "entry 0 reset");
		rd(ADDR_CAL_RESULT, 8'h3f, "cal reset");
		rd(8'h20, 8'h00, "unmapped read");
		$display("reset test done");
		for (int i = 0; i < 3; i++) begin
			base = rnd() % 32'h0100_0000;
			slot = rnd() % 256;
			mant = rnd() % 256;
			expo = rnd() % 4;
			ifw = rnd() % 256;
			// tuning registers only change while the radio is idle
			wr(ADDR_BASE_HIGH, 8'(base >> 16));
			rd(ADDR_BASE_HIGH, 8'(base >> 16), "base high");
			wr(ADDR_BASE_MID, 8'(base >> 8));
			wr(ADDR_BASE_LOW, 8'(base));
			wr(ADDR_SLOT, 8'(slot));
			wr(ADDR_MODEM_LOW, 8'(mant));
			wr(ADDR_MODEM_HIGH, 8'(expo));
			wr(ADDR_SYNTH_CTRL, 8'(ifw));
			wr(ADDR_RADIO_CFG, 8'h00);
			cal = (rnd() % 63);
			vco_cal_code = 6'(cal);
			// first round fails to lock, so calibration is repeated
			for (int k = (i == 0) ? 0 : 1; k < 2; k++) begin
				pll_lock_in = k[0];
				repeat (5) @(negedge clk);
				pulse(cal_strobe);
				chk_bit(cal_busy, 1'b1, "cal busy");
				wait_for(cal_busy, 1'b0, 40);
				rd(ADDR_CAL_RESULT, (k == 1) ? 8'(cal) : 8'h3f, "cal result");
			end
			start_tx = 1'b0;
			pulse(start_req);
			@(negedge clk);
			off = (slot * (256 + mant)) << expo;
			chk_word(synth_word, 25'(base + (off >> 2)), "synth word");
			chk_byte(if_word, 8'(ifw), "if word");
			chk_bit(synth_run, 1'b1, "synth run");
			pulse(stop_req);
			wait_for(radio_idle, 1'b1, 60);
		end
		$display("tuning test done");
		wr(ADDR_PIN_CFG, 8'h0a);
		repeat (6) @(negedge clk);
		chk_bit(general_output_pin, 1'b1, "lock pin");
		pll_lock_in = 1'b0;
		repeat (6) @(negedge clk);
		chk_bit(general_output_pin, 1'b0, "lock pin low");
		pll_lock_in = 1'b1;
		wr(ADDR_PIN_CFG, 8'h00);
		repeat (6) @(negedge clk);
		chk_bit(general_output_pin, 1'b0, "other selector");
		$display("lock pin test done");
		for (int i = 0; i < 8; i++) begin
			tbl[i] = 8'(rnd());
			if (tbl[i] >= 8'h61 && tbl[i] <= 8'h6f) tbl[i] = 8'h60;
			pt[i] = tbl[i];
		end
		u_host.burst(ADDR_POWER_TABLE, 1'b1, tbl);
		pt[0] = 8'h51;
		wr(ADDR_POWER_TABLE, 8'h51);
		u_host.burst(ADDR_POWER_TABLE, 1'b0, tbl);
		for (int i = 0; i < 8; i++) chk_byte(tbl[i], 8'(pt[i]), "table");
		tx_run(0);
		tx_run(3);
		tx_run(7);
		$display("ramp test done");
		ook_mode = 1'b1;
		wr(ADDR_FRONT_END, 8'h01);
		start_tx = 1'b1;
		pulse(start_req);
		for (int s = 0; s < 3; s++) begin
			ook_symbol = s[0];
			repeat (4) @(negedge clk);
			chk_byte(pa_level, 8'(pt[s % 2]), "keyed level");
		end
		pulse(stop_req);
		wait_for(radio_idle, 1'b1, 400);
		ook_mode = 1'b0;
		$display("keying test done");
		wr(ADDR_RADIO_CFG, 8'h10);
		start_tx = 1'b0;
		pulse(start_req);
		chk_bit(cal_busy, 1'b1, "cal on start");
		wait_for(cal_busy, 1'b0, 40);
		pulse(stop_req);
		wait_for(radio_idle, 1'b1, 60);
		wr(ADDR_RADIO_CFG, 8'h20);
		pulse(start_req);
		chk_bit(cal_busy, 1'b0, "no cal on start");
		stop_auto = 1'b1;
		pulse(stop_req);
		stop_auto = 1'b0;
		wait_for(cal_busy, 1'b1, 60);
		wait_for(radio_idle, 1'b1, 60);
		wr(ADDR_RADIO_CFG, 8'h00);
		$display("auto cal test done");
		pulse(sleep_req);
		repeat (3) @(negedge clk);
		pulse(wake_req);
		repeat (3) @(negedge clk);
		rd(ADDR_CAL_RESULT, 8'(cal), "cal after sleep");
		u_host.burst(ADDR_POWER_TABLE, 1'b0, tbl);
		for (int i = 1; i < 8; i++) pt[i] = 0;
		for (int i = 0; i < 8; i++) chk_byte(tbl[i], 8'(pt[i]), "after sleep");
		$display("sleep test done");
		results();
	end
endmodule : stp_synth_power_bench
`default_nettype wire
